// >>> design/spi_control_status_fields.v
// serial port: control/status fields, word shifter and wishbone slave
// assumes a classic wishbone master and a peer serial port on the pins
`include "spi_port_defs.vh"
`default_nettype none

module spi_control_status_fields #(
  parameter WORD_BITS = 8
) (
  input wire clock,
  input wire rstn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire sclk_i,
  output reg sclk_o,
  output wire sclk_oe,
  input wire mosi_i,
  output reg mosi_o,
  output wire mosi_oe,
  input wire miso_i,
  output reg miso_o,
  output wire miso_oe,
  input wire select_in_n,
  output reg select_out_n,
  output reg irq
);

  // ************************************************
  // states
  // ************************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_GAP = 3'b100;
  localparam CW = $clog2(2 * WORD_BITS + 1);

  // ************************************************
  // registers
  // ************************************************
  reg [11:4] ctl_q;
  reg rx_full_q, ovr_q, fault_q, tx_empty_q, ovr_armed_q;
  reg [7:0] half_q;
  reg auto_q, pulse_q;
  reg [WORD_BITS-1:0] tx_hold_q, rx_hold_q, shift_q;
  reg [2:0] state_q;
  reg [7:0] div_q;
  reg [CW-1:0] edge_q;
  reg sclk_prev_q, sel_prev_q;

  wire err_en = ctl_q[`ERROR_IRQ_ENABLE_BIT];
  wire fault_en = ctl_q[`FAULT_DETECT_ENABLE_BIT];
  wire rx_en = ctl_q[`RX_IRQ_ENABLE_BIT];
  wire ctrl = ctl_q[`CONTROLLER_SELECT_BIT];
  wire clock_idle_polarity = ctl_q[`CLOCK_IDLE_POLARITY_BIT];
  wire clock_phase_select = ctl_q[`CLOCK_PHASE_SELECT_BIT];
  wire enable = ctl_q[`PORT_ENABLE_BIT];
  wire tx_en = ctl_q[`TX_IRQ_ENABLE_BIT];

  // ************************************************
  // pin synchronisers
  // ************************************************
  wire sclk_s, mosi_s, miso_s, sel_s;
  sync_two_stage #(
    .WIDTH(4)
  ) u_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in({sclk_i, mosi_i, miso_i, select_in_n}),
    .sync_out({sclk_s, mosi_s, miso_s, sel_s})
  );

  // ************************************************
  // bus decode
  // ************************************************
  wire req = wb_cyc_i & wb_stb_i;
  wire acc = req & wb_ack_o;
  wire wr = acc & wb_we_i;
  wire rd = acc & ~wb_we_i;
  wire hit_sc = wb_adr_i == `STATUS_CONTROL_OFS;
  wire hit_tx = wb_adr_i == `TX_DATA_OFS;
  wire hit_rx = wb_adr_i == `RX_DATA_OFS;
  wire hit_lc = wb_adr_i == `LINK_CONTROL_OFS;

  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        lane_merge[8*i +: 8] = sel[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
      end
    end
  endfunction

  wire [15:0] status_word = {4'h0, ctl_q, rx_full_q, ovr_q, fault_q,
                             tx_empty_q};
  wire [31:0] sc_new = lane_merge({16'h0000, status_word}, wb_dat_i,
                                  wb_sel_i);
  wire [31:0] lc_new = lane_merge({22'h000000, pulse_q, auto_q, half_q},
                                  wb_dat_i, wb_sel_i);

  // ************************************************
  // link event detection
  // ************************************************
  // controller: sclk comes from our own divider; target: from synced pin
  wire half_tick = (state_q == ST_RUN) && (div_q == 8'h00);
  wire tgt_act = enable & ~ctrl & ~sel_s;
  wire sclk_edge = ctrl ? half_tick : (tgt_act & (sclk_s ^ sclk_prev_q));
  // leading edge leaves the idle level
  wire leading = ctrl ? (sclk_o == clock_idle_polarity) : (sclk_s != clock_idle_polarity);
  wire sample = sclk_edge & (leading ^ clock_phase_select);
  wire launch = sclk_edge & ~(leading ^ clock_phase_select);
  wire din = ctrl ? miso_s : mosi_s;
  wire [WORD_BITS-1:0] shifted = {shift_q[WORD_BITS-2:0], din};
  // a word ends on its last edge; with phase 0 the last sample came before
  wire word_done = sclk_edge && (edge_q == 2 * WORD_BITS - 1);
  wire [WORD_BITS-1:0] rx_word = sample ? shifted : shift_q;
  // controller fault: select low; only seen with fault detect on
  wire ctrl_fault = enable & ctrl & fault_en & ~sel_s;
  // target fault: select rises with a word part way through
  wire tgt_fault = enable & ~ctrl & fault_en & sel_s & ~sel_prev_q &
                   (edge_q != {CW{1'b0}});
  wire fault_set = ctrl_fault | tgt_fault;
  wire sel_fall = ~sel_s & sel_prev_q;
  wire start_ctrl = enable & ctrl & ~ctrl_fault & ~tx_empty_q &
                    (state_q == ST_IDLE);
  wire load_tgt = tgt_act & (sel_fall | word_done);
  wire take_hold = start_ctrl | load_tgt | (ctrl & word_done & ~tx_empty_q);
  wire [WORD_BITS-1:0] next_word = tx_empty_q ? {WORD_BITS{1'b0}} :
                                                 tx_hold_q;
  // the data line is loaded from the head of the shift register, or of the next word when one is taken
  wire out_bit = take_hold ? next_word[WORD_BITS-1] : shift_q[WORD_BITS-1];

  // ************************************************
  // wishbone slave
  // ************************************************
  // one wait state: ack rises the cycle after the request, data with it
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o) begin
        if (hit_sc) begin
          wb_dat_o <= {16'h0000, status_word};
        end else if (hit_rx) begin
          wb_dat_o <= {{(32-WORD_BITS){1'b0}}, rx_hold_q};
        end else if (hit_lc) begin
          wb_dat_o <= {22'h000000, pulse_q, auto_q, half_q};
        end else begin
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

  // ************************************************
  // control and status fields
  // ************************************************
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctl_q <= `STATUS_CONTROL_RESET;
      half_q <= `HALF_PERIOD_RESET;
      auto_q <= 1'b0;
      pulse_q <= 1'b0;
      fault_q <= 1'b0;
      rx_full_q <= 1'b0;
      ovr_q <= 1'b0;
      ovr_armed_q <= 1'b0;
      tx_empty_q <= 1'b1;
      tx_hold_q <= {WORD_BITS{1'b0}};
      rx_hold_q <= {WORD_BITS{1'b0}};
    end else begin
      if (wr & hit_sc) begin
        // fault flag stays unless written with one
        ctl_q <= sc_new[11:4];
      end
      if (wr & hit_lc) begin
        half_q <= lc_new[`HALF_PERIOD_MSB:`HALF_PERIOD_LSB];
        auto_q <= lc_new[`AUTO_SELECT_DRIVE_BIT];
        pulse_q <= lc_new[`SELECT_PULSE_BIT];
      end
      // controller fault drops the enable, winning over a write
      if (ctrl_fault) begin
        ctl_q[`PORT_ENABLE_BIT] <= 1'b0;
      end
      // set wins over the write-one clear
      if (fault_set) begin
        fault_q <= 1'b1;
      end else if (wr & hit_sc & sc_new[`SELECT_FAULT_FLAG_BIT]) begin
        fault_q <= 1'b0;
      end
      if (rd & hit_sc & ovr_q) begin
        ovr_armed_q <= 1'b1;
      end
      if (!enable) begin
        // partial reset: transfer state and data flags, not the fields
        rx_full_q <= 1'b0;
        ovr_q <= 1'b0;
        ovr_armed_q <= 1'b0;
        tx_empty_q <= 1'b1;
      end else begin
        if (word_done & rx_full_q) begin
          ovr_q <= 1'b1;
        end else if (rd & hit_rx & ovr_armed_q) begin
          ovr_q <= 1'b0;
          ovr_armed_q <= 1'b0;
        end
        if (word_done & ~rx_full_q) begin
          rx_hold_q <= rx_word;
          rx_full_q <= 1'b1;
        end else if (rd & hit_rx) begin
          rx_full_q <= 1'b0;
        end
        if (wr & hit_tx) begin
          tx_hold_q <= wb_dat_i[WORD_BITS-1:0];
          tx_empty_q <= 1'b0;
        end else if (take_hold) begin
          tx_empty_q <= 1'b1;
        end
      end
    end
  end

  // ************************************************
  // word shifter
  // ************************************************
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      div_q <= 8'h00;
      edge_q <= {CW{1'b0}};
      shift_q <= {WORD_BITS{1'b0}};
      sclk_o <= 1'b0;
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
      sclk_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      sel_prev_q <= sel_s;
      if (!enable || ctrl_fault) begin
        // abort and partial reset return the link to idle
        state_q <= ST_IDLE;
        edge_q <= {CW{1'b0}};
        sclk_o <= clock_idle_polarity;
      end else begin
        if (state_q == ST_RUN || state_q == ST_GAP) begin
          div_q <= (div_q == 8'h00) ? half_q : div_q - 8'h01;
        end
        if (half_tick) begin
          sclk_o <= ~sclk_o;
        end
        if (sclk_edge) begin
          edge_q <= word_done ? {CW{1'b0}} : edge_q + 1'b1;
        end
        if (!ctrl && sel_s) begin
          edge_q <= {CW{1'b0}};
        end
        if (sample) begin
          shift_q <= shifted;
        end
        // a sample edge already moved the next bit to the head
        if (launch | take_hold) begin
          if (ctrl) begin
            mosi_o <= out_bit;
          end else begin
            miso_o <= out_bit;
          end
        end
        if (take_hold) begin
          shift_q <= next_word;
        end
        case (state_q)
          ST_IDLE: begin
            sclk_o <= clock_idle_polarity;
            div_q <= half_q;
            if (start_ctrl) begin
              state_q <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (ctrl & word_done) begin
              if (tx_empty_q) begin
                state_q <= ST_IDLE;
              end else if (auto_q & pulse_q) begin
                state_q <= ST_GAP;
              end
            end
          end
          ST_GAP: begin
            // select held high for one half period between words
            if (div_q == 8'h00) begin
              state_q <= ST_RUN;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  // drives follow the role; a target only drives miso while selected
  assign sclk_oe = enable & ctrl;
  assign mosi_oe = enable & ctrl;
  assign miso_oe = tgt_act;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      select_out_n <= 1'b1;
      irq <= 1'b0;
    end else begin
      select_out_n <= ~(auto_q & enable & ctrl &
                        (state_q == ST_RUN));
      irq <= (err_en & (fault_q | ovr_q)) |
             (rx_en & rx_full_q) |
             (tx_en & tx_empty_q);
    end
  end

endmodule

`default_nettype wire

// >>> design/sync_two_stage.v
// two flip-flop synchroniser for a group of unrelated level inputs
// assumes each bit is a slow level or is sampled again downstream
`default_nettype none

module sync_two_stage #(
  parameter WIDTH = 1
) (
  input wire clock,
  input wire rstn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] stable_q;

  // first stage feeds only the second stage
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= {WIDTH{1'b0}};
      stable_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule

`default_nettype wire

// >>> include/spi_port_defs.vh
// register offsets, field positions and reset values of the serial port
// assumes byte addresses on a 32-bit classic wishbone bus
`ifndef SPI_PORT_DEFS_VH
`define SPI_PORT_DEFS_VH

// ************************************************
// register byte offsets
// ************************************************
`define STATUS_CONTROL_OFS 8'h00
`define TX_DATA_OFS 8'h04
`define RX_DATA_OFS 8'h08
`define LINK_CONTROL_OFS 8'h0c

// ************************************************
// serial_port_status_control fields
// ************************************************
`define ERROR_IRQ_ENABLE_BIT 11
`define FAULT_DETECT_ENABLE_BIT 10
`define RX_IRQ_ENABLE_BIT 9
`define CONTROLLER_SELECT_BIT 8
`define CLOCK_IDLE_POLARITY_BIT 7
`define CLOCK_PHASE_SELECT_BIT 6
`define PORT_ENABLE_BIT 5
`define TX_IRQ_ENABLE_BIT 4
`define RX_FULL_FLAG_BIT 3
`define RECEIVE_OVERRUN_FLAG_BIT 2
`define SELECT_FAULT_FLAG_BIT 1
`define TX_EMPTY_FLAG_BIT 0
// writable bits 11..4 reset to zero; tx_empty_flag resets to one
`define STATUS_CONTROL_RESET 8'h00

// ************************************************
// link_control fields
// ************************************************
`define HALF_PERIOD_LSB 0
`define HALF_PERIOD_MSB 7
`define AUTO_SELECT_DRIVE_BIT 8
`define SELECT_PULSE_BIT 9
`define HALF_PERIOD_RESET 8'h08

`endif

// >>> test/spi_csf_asserts.sv
// checker for the serial port control/status block
// sees only the top module's ports; bound at the foot of this file
`default_nettype none
// ****
// checker
// ****
module spi_csf_asserts (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic sclk_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic select_in_n,
  input wire logic select_out_n,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] ctl_q;
  logic en_off;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // shadow of written fields; bit 5 goes stale when a fault clears it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      ctl_q <= 12'h000;
    else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00)
      ctl_q <= wb_dat_i[11:0];
  end
  assign en_off = !ctl_q[11] && !ctl_q[9] && !ctl_q[4];
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  ack_turn_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("no ack after request");
  oe_pair_a: assert property (mosi_oe == sclk_oe &&
    !(miso_oe && sclk_oe)) else $error("enables disagree with mode");
  miso_sel_a: assert property (miso_oe |->
    !$past(select_in_n, 2) || !$past(select_in_n, 3))
    else $error("target drives while unselected");
  fault_abort_a: assert property (
    $fell(select_in_n) && sclk_oe && ctl_q[10] |-> ##[1:4] !sclk_oe)
    else $error("controller kept running on fault");
  ignore_sel_a: assert property (
    sclk_oe && !ctl_q[10] && !wb_ack_o |=> sclk_oe)
    else $error("controller stopped without fault detect");
  select_oe_a: assert property ($fell(select_out_n) |-> sclk_oe)
    else $error("select driven by a disabled port");
  irq_gate_a: assert property (en_off[*2] |-> !irq)
    else $error("interrupt with every enable clear");
endmodule
bind spi_control_status_fields spi_csf_asserts u_spi_csf_asserts (
  .clock, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
  .wb_ack_o, .sclk_oe, .mosi_oe, .miso_oe, .select_in_n, .select_out_n,
  .irq);
`default_nettype wire

// >>> test/spi_peer_target.sv
// behavioural target port on the far side of the link
// assumes clock and data lines already resolved from the enables
`default_nettype none
module spi_peer_target (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic clock_idle_polarity,
  input wire logic clock_phase_select,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh;
  initial miso = 1'h0;
  // phase 0 puts the first bit out on select, before any clock edge
  always @(negedge sel_n) begin
    sh = tx;
    if (!clock_phase_select)
      miso = sh[7];
  end
  // sample on the leading edge for phase 0, trailing for phase 1
  always @(sclk) begin
    if (!sel_n && (sclk != clock_idle_polarity) != clock_phase_select) begin
      sh = {sh[6:0], mosi};
      rx = sh;
    end else if (!sel_n)
      miso = sh[7];
  end
  // released line flips to the inverse of its last bit
  always @(posedge sel_n) miso = ~miso;
endmodule
`default_nettype wire

// >>> test/tb.sv
// testbench for the serial port control/status block
// assumes the checker binds itself and the peer target sits on the link
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'h0, rstn = 1'h0, frame_on = 1'h0;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00, peer_tx = 8'h00, peer_rx;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic select_out_n, irq, peer_miso, clock_idle_polarity = 1'h0, clock_phase_select = 1'h0;
  logic sclk_i = 1'h0, mosi_i = 1'h0, select_in_n = 1'h1;
  int err_total = 0, n_checks = 0;
  always #2 clock = ~clock;
  // link clock runs only inside target frames
  always #24 if (frame_on) begin
    sclk_i = ~sclk_i;
    mosi_i = ~mosi_i;
  end
  spi_control_status_fields u_spi_control_status_fields (
    .clock, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .sclk_i, .sclk_o, .sclk_oe, .mosi_i,
    .mosi_o, .mosi_oe, .miso_i(peer_miso), .miso_o, .miso_oe,
    .select_in_n, .select_out_n, .irq);
  spi_peer_target u_spi_peer_target (
    .sclk(sclk_oe ? sclk_o : clock_idle_polarity), .mosi(mosi_oe ? mosi_o : 1'h1),
    .sel_n(select_out_n), .clock_idle_polarity, .clock_phase_select, .tx(peer_tx),
    .miso(peer_miso), .rx(peer_rx));
  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clock); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, exp);
    bus(1'h0, a, 32'h0);
    chk(q & m, exp);
  endtask
  task automatic word(input logic [7:0] d);
    wr(8'h04, {24'h0, d});
    wait (select_out_n === 1'h0);
    wait (select_out_n === 1'h1);
    tick(4);
  endtask
  task automatic frame;
    select_in_n <= 1'h0;
    tick(2);
    frame_on = 1'h1;
    repeat (4) @(sclk_i);
    frame_on = 1'h0;
    @(posedge clock);
    select_in_n <= 1'h1;
    tick(8);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    rd(8'h00, 32'hffff, 32'h1);
    rd(8'h10, 32'hffffffff, 32'h0);
    rd(8'h0c, 32'h3ff, 32'h8);
  endtask
  task automatic t_fields;
    wr(8'h00, 32'hfd0);
    rd(8'h00, 32'hffff, 32'hfd1);
    tick(3);
    chk(irq, 1'h1);
    wr(8'h00, 32'h0);
    tick(3);
    chk(irq, 1'h0);
  endtask
  // select input held low throughout: must not matter here
  task automatic t_modes;
    logic [31:0] c;
    select_in_n <= 1'h0;
    // the peer only sees a word while the controller drives select
    wr(8'h0c, 32'h108);
    for (int m = 0; m < 4; m++) begin
      c = 32'h100 | (m << 6);
      {clock_idle_polarity, clock_phase_select} = m[1:0];
      peer_tx = 8'h3c ^ m[7:0];
      wr(8'h00, c);
      wr(8'h00, c | 32'h20);
      tick(3);
      chk(sclk_o, clock_idle_polarity);
      word(8'ha5 + m[7:0]);
      rd(8'h08, 32'hff, {24'h0, peer_tx});
      chk(peer_rx, 8'ha5 + m[7:0]);
      wr(8'h00, c);
    end
    select_in_n <= 1'h1;
  endtask
  // back-to-back words with a select pulse between them
  task automatic t_pulse;
    {clock_idle_polarity, clock_phase_select} = 2'h0;
    wr(8'h0c, 32'h308);
    wr(8'h00, 32'h100);
    wr(8'h00, 32'h120);
    peer_tx = 8'h96;
    wr(8'h04, 32'h3c);
    wait (select_out_n === 1'h0);
    wr(8'h04, 32'hc3);
    wait (select_out_n === 1'h1);
    tick(2);
    chk(peer_rx, 8'h3c);
    chk(select_out_n, 1'h1);
    wait (select_out_n === 1'h0);
    wait (select_out_n === 1'h1);
    tick(4);
    chk(peer_rx, 8'hc3);
    rd(8'h00, 32'hffff, 32'h12d);
    rd(8'h08, 32'hff, 32'h96);
    wr(8'h00, 32'h100);
    wr(8'h0c, 32'h108);
  endtask
  task automatic t_overrun;
    {clock_idle_polarity, clock_phase_select} = 2'h0;
    wr(8'h00, 32'h100);
    wr(8'h00, 32'h120);
    peer_tx = 8'h77;
    word(8'h01);
    peer_tx = 8'h11;
    word(8'h02);
    rd(8'h00, 32'hffff, 32'h12d);
    chk(irq, 1'h0);
    wr(8'h00, 32'h920);
    tick(3);
    chk(irq, 1'h1);
    wr(8'h00, 32'h320);
    tick(3);
    chk(irq, 1'h1);
    wr(8'h00, 32'h120);
    rd(8'h08, 32'hff, 32'h77);
    rd(8'h00, 32'hffff, 32'h121);
    wr(8'h00, 32'h100);
    rd(8'h00, 32'hffff, 32'h101);
  endtask
  task automatic t_cfault;
    wr(8'h00, 32'h500);
    wr(8'h00, 32'h520);
    wr(8'h04, 32'h55);
    tick(20);
    select_in_n <= 1'h0;
    tick(8);
    rd(8'h00, 32'hffff, 32'h503);
    select_in_n <= 1'h1;
    tick(4);
    wr(8'h00, 32'h502);
    rd(8'h00, 32'hffff, 32'h501);
  endtask
  task automatic t_tfault;
    wr(8'h00, 32'h400);
    wr(8'h00, 32'h420);
    wr(8'h04, 32'h5a);
    frame();
    rd(8'h00, 32'h2, 32'h2);
    wr(8'h00, 32'h020);
    rd(8'h00, 32'h402, 32'h2);
    wr(8'h00, 32'h022);
    rd(8'h00, 32'h2, 32'h0);
    frame();
    rd(8'h00, 32'h2, 32'h0);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // run takes under two thousand cycles; the limit leaves ample margin
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    close_out();
  end
  initial begin
    tick(3);
    rstn <= 1'h1;
    t_reset();
    t_fields();
    t_modes();
    t_pulse();
    t_overrun();
    t_cfault();
    t_tfault();
    close_out();
  end
endmodule
`default_nettype wire
